/* src/disk_log_pkg.sv */
// constants, offsets and state encodings for the log write command logic
package disk_log_pkg;
    // ------------------------------------------------------------------
    // register offsets (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_FEAT_CUR = 8'h00;
    localparam logic [7:0] OFF_FEAT_PREV = 8'h04;
    localparam logic [7:0] OFF_CNT_CUR = 8'h08;
    localparam logic [7:0] OFF_CNT_PREV = 8'h0C;
    localparam logic [7:0] OFF_SNUM_CUR = 8'h10;
    localparam logic [7:0] OFF_SNUM_PREV = 8'h14;
    localparam logic [7:0] OFF_CYLLO_CUR = 8'h18;
    localparam logic [7:0] OFF_CYLLO_PREV = 8'h1C;
    localparam logic [7:0] OFF_CYLHI_CUR = 8'h20;
    localparam logic [7:0] OFF_CYLHI_PREV = 8'h24;
    localparam logic [7:0] OFF_DEVHEAD = 8'h28;
    localparam logic [7:0] OFF_CMD_STATUS = 8'h2C;
    localparam logic [7:0] OFF_ERROR = 8'h30;
    localparam logic [7:0] OFF_DEVCTL = 8'h34;
    localparam logic [7:0] OFF_DATA = 8'h38;
    localparam int unsigned TF_REGS = 11;

    // ------------------------------------------------------------------
    // opcodes, bit positions, sizes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_LOG_EXT = 8'h3F;
    localparam logic [7:0] CMD_WRITE_FPDMA = 8'h61;
    localparam int unsigned ST_BSY = 7;
    localparam int unsigned ST_RDY = 6;
    localparam int unsigned ST_DSC = 4;
    localparam int unsigned ST_DRQ = 3;
    localparam int unsigned ST_ERR = 0;
    localparam int unsigned ER_UNC = 6;
    localparam int unsigned ER_ABT = 2;
    localparam int unsigned DH_FUA = 7;
    localparam int unsigned DC_HOB = 7;
    localparam int unsigned SECTOR_BYTES = 512;
    localparam int unsigned WORDS_PER_SECTOR = SECTOR_BYTES / 4;
    localparam int unsigned WORD_CNT_W = $clog2(WORDS_PER_SECTOR);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] TF_RESET = 8'h00;
    localparam logic [47:0] LBA_RESET = 48'h0000_0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CHECK = 2'b01,
        ST_XFER = 2'b10,
        ST_FLUSH = 2'b11
    } cmd_state_t;
endpackage

/* src/word_stream_if.sv */
// valid/ready word stream between the command logic and its fifo
`timescale 1ns/10ps
`default_nettype none
interface word_stream_if #(parameter int unsigned WIDTH = 32);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* src/word_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 32
) (
    input wire logic mclk,
    input wire logic rst_n,
    word_stream_if.snk in_s,
    word_stream_if.src out_s
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0] wr_ptr_q;
    logic [PW:0] rd_ptr_q;
    logic full;
    logic empty;
    logic push;
    logic pop;

    // extra pointer bit tells full from empty
    assign empty = (wr_ptr_q == rd_ptr_q);
    assign full = (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]) && (wr_ptr_q[PW] != rd_ptr_q[PW]);
    assign in_s.ready = !full;
    assign out_s.valid = !empty;
    assign out_s.data = mem_q[rd_ptr_q[PW-1:0]];
    assign push = in_s.valid && !full;
    assign pop = out_s.ready && !empty;

    // pointers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

    // storage, no reset needed on data
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_ptr_q[PW-1:0]] <= in_s.data;
        end
    end
endmodule
`default_nettype wire

/* src/disk_write_log_command_logic.sv */
// task-file command logic for queued writes and extended log writes
`timescale 1ns/10ps
`default_nettype none
module disk_write_log_command_logic #(
    parameter int unsigned FIFO_DEPTH = 32,
    parameter int unsigned BLOCK_SECTORS = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic write_cache_en,
    input wire logic [15:0] log_dir_size,
    input wire logic log_read_only,
    input wire logic log_feature_ok,
    output logic [7:0] log_addr,
    output logic [15:0] log_start_sector,
    output logic log_write_active,
    output logic [31:0] media_data,
    output logic media_valid,
    input wire logic media_ready,
    input wire logic media_commit_done,
    input wire logic media_unc_err,
    input wire logic [47:0] media_unc_lba,
    output logic intrq,
    output logic busy
);
    localparam logic [15:0] BLOCK_LAST = 16'(BLOCK_SECTORS - 1);
    localparam logic [6:0] WORD_LAST = 7'(disk_log_pkg::WORDS_PER_SECTOR - 1);

    word_stream_if #(.WIDTH(32)) push_s ();
    word_stream_if #(.WIDTH(32)) drain_s ();

    disk_log_pkg::cmd_state_t state_q;
    logic [7:0] tf_q [disk_log_pkg::TF_REGS];
    logic [7:0] cmd_q;
    logic hob_q;
    logic drq_q;
    logic err_abt_q;
    logic err_unc_q;
    logic intrq_q;
    logic fua_need_q;
    logic is_log_q;
    logic unc_seen_q;
    logic [47:0] unc_lba_q;
    logic [15:0] sectors_left_q;
    logic [15:0] blk_cnt_q;
    logic [6:0] word_cnt_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic write_go;
    logic cmd_start;
    logic data_push;
    logic status_read;
    logic [15:0] req_count;
    logic [16:0] req_end;
    logic log_abort;
    logic sector_end;
    logic last_word;
    logic unc_hit;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [3:0] wr_idx;

    // ------------------------------------------------------------------
    // bus write side: address and data taken together
    // ------------------------------------------------------------------
    // a data write stalls here while the fifo is full, so back-pressure
    // reaches the host through wready instead of losing words
    assign write_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q &&
        (s_axi_awaddr != disk_log_pkg::OFF_DATA || !drq_q || push_s.ready);
    assign s_axi_awready = write_go;
    assign s_axi_wready = write_go;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign wr_idx = s_axi_awaddr[5:2];
    assign cmd_start = write_go && s_axi_awaddr == disk_log_pkg::OFF_CMD_STATUS &&
        s_axi_wstrb[0] && state_q == disk_log_pkg::ST_IDLE;
    assign data_push = write_go && s_axi_awaddr == disk_log_pkg::OFF_DATA && drq_q;
    assign push_s.valid = data_push;
    assign push_s.data = s_axi_wdata;

    // write response, unmapped offsets answer slverr
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= disk_log_pkg::RESP_OKAY;
        end else if (write_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= (s_axi_awaddr[1:0] == 2'h0 && s_axi_awaddr <= disk_log_pkg::OFF_DATA) ?
                disk_log_pkg::RESP_OKAY : disk_log_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // task-file bytes, frozen while a command runs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < disk_log_pkg::TF_REGS; i++) begin
                tf_q[i] <= disk_log_pkg::TF_RESET;
            end
        end else if (write_go && s_axi_wstrb[0] && s_axi_awaddr[1:0] == 2'h0 &&
                     s_axi_awaddr[7:6] == 2'h0 && 32'(wr_idx) < disk_log_pkg::TF_REGS &&
                     state_q == disk_log_pkg::ST_IDLE) begin
            tf_q[wr_idx] <= s_axi_wdata[7:0];
        end
    end

    // high-order-byte view select
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hob_q <= 1'b0;
        end else if (write_go && s_axi_wstrb[0] && s_axi_awaddr == disk_log_pkg::OFF_DEVCTL) begin
            hob_q <= s_axi_wdata[disk_log_pkg::DC_HOB];
        end
    end

    // ------------------------------------------------------------------
    // command checks
    // ------------------------------------------------------------------
    assign req_count = {tf_q[3], tf_q[2]};
    assign log_addr = tf_q[4];
    assign log_start_sector = {tf_q[7], tf_q[6]};
    assign req_end = {1'b0, log_start_sector} + {1'b0, req_count};
    // every reason to refuse is known before drq rises
    assign log_abort = (req_count > log_dir_size) ||
        log_read_only ||
        !log_feature_ok || req_count == 16'h0000 ||
        log_start_sector >= log_dir_size || req_end > {1'b0, log_dir_size};
    assign log_write_active = is_log_q && state_q != disk_log_pkg::ST_IDLE;

    assign last_word = word_cnt_q == WORD_LAST;
    assign sector_end = data_push && last_word;
    assign unc_hit = media_unc_err && !is_log_q &&
        (state_q == disk_log_pkg::ST_XFER || state_q == disk_log_pkg::ST_FLUSH);

    // ------------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= disk_log_pkg::ST_IDLE;
            cmd_q <= disk_log_pkg::TF_RESET;
            drq_q <= 1'b0;
            err_abt_q <= 1'b0;
            err_unc_q <= 1'b0;
            fua_need_q <= 1'b0;
            is_log_q <= 1'b0;
            sectors_left_q <= 16'h0000;
        end else begin
            case (state_q)
                disk_log_pkg::ST_IDLE: begin
                    if (cmd_start) begin
                        cmd_q <= s_axi_wdata[7:0];
                        is_log_q <= s_axi_wdata[7:0] == disk_log_pkg::CMD_WRITE_LOG_EXT;
                        err_abt_q <= 1'b0;
                        err_unc_q <= 1'b0;
                        state_q <= disk_log_pkg::ST_CHECK;
                    end
                end
                disk_log_pkg::ST_CHECK: begin
                    // fua forces media commit on queued writes; a disabled cache does as well
                    fua_need_q <= tf_q[10][disk_log_pkg::DH_FUA] || !write_cache_en;
                    if (cmd_q == disk_log_pkg::CMD_WRITE_LOG_EXT && !log_abort) begin
                        sectors_left_q <= req_count;
                        drq_q <= 1'b1;
                        state_q <= disk_log_pkg::ST_XFER;
                    end else if (cmd_q == disk_log_pkg::CMD_WRITE_FPDMA &&
                                 {tf_q[1], tf_q[0]} != 16'h0000) begin
                        sectors_left_q <= {tf_q[1], tf_q[0]};
                        drq_q <= 1'b1;
                        state_q <= disk_log_pkg::ST_XFER;
                    end else begin
                        err_abt_q <= 1'b1;
                        state_q <= disk_log_pkg::ST_IDLE;
                    end
                end
                disk_log_pkg::ST_XFER: begin
                    if (unc_hit) begin
                        drq_q <= 1'b0;
                        err_unc_q <= 1'b1;
                        state_q <= disk_log_pkg::ST_IDLE;
                    end else if (sector_end) begin
                        sectors_left_q <= sectors_left_q - 16'h0001;
                        if (sectors_left_q == 16'h0001) begin
                            drq_q <= 1'b0;
                            state_q <= disk_log_pkg::ST_FLUSH;
                        end
                    end
                end
                disk_log_pkg::ST_FLUSH: begin
                    if (unc_hit) begin
                        err_unc_q <= 1'b1;
                        state_q <= disk_log_pkg::ST_IDLE;
                    end else if (!is_log_q && !fua_need_q) begin
                        state_q <= disk_log_pkg::ST_IDLE;
                    end else if (!drain_s.valid && (!fua_need_q || is_log_q || media_commit_done)) begin
                        state_q <= disk_log_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= disk_log_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // word and block counters within the data phase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            word_cnt_q <= 7'h00;
            blk_cnt_q <= 16'h0000;
        end else if (state_q == disk_log_pkg::ST_CHECK) begin
            word_cnt_q <= 7'h00;
            blk_cnt_q <= 16'h0000;
        end else if (data_push) begin
            word_cnt_q <= last_word ? 7'h00 : word_cnt_q + 7'h01;
            if (last_word) begin
                blk_cnt_q <= (blk_cnt_q == BLOCK_LAST) ? 16'h0000 : blk_cnt_q + 16'h0001;
            end
        end
    end

    // first unrecoverable error address, kept until an error in a later command replaces it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            unc_seen_q <= 1'b0;
            unc_lba_q <= disk_log_pkg::LBA_RESET;
        end else if (state_q == disk_log_pkg::ST_CHECK) begin
            unc_seen_q <= 1'b0;
        end else if (unc_hit && !unc_seen_q) begin
            unc_seen_q <= 1'b1;
            unc_lba_q <= media_unc_lba;
        end
    end

    // ------------------------------------------------------------------
    // interrupt: per block on log writes, the last with the final sector; at the end of queued writes and refused commands
    // ------------------------------------------------------------------
    // a new event in the cycle of a status read keeps the line high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            intrq_q <= 1'b0;
        end else if ((sector_end && is_log_q &&
                      (blk_cnt_q == BLOCK_LAST || sectors_left_q == 16'h0001)) ||
                     unc_hit || (state_q == disk_log_pkg::ST_FLUSH && !is_log_q &&
                      (!fua_need_q || (!drain_s.valid && media_commit_done)))) begin
            intrq_q <= 1'b1; // waits for the commit only on queued writes with fua_need_q set
        end else if (state_q == disk_log_pkg::ST_CHECK && !drq_q &&
                     !(cmd_q == disk_log_pkg::CMD_WRITE_LOG_EXT && !log_abort) &&
                     !(cmd_q == disk_log_pkg::CMD_WRITE_FPDMA &&
                       {tf_q[1], tf_q[0]} != 16'h0000)) begin
            intrq_q <= 1'b1;
        end else if (status_read) begin
            intrq_q <= 1'b0;
        end
    end
    assign intrq = intrq_q;
    assign busy = state_q != disk_log_pkg::ST_IDLE;

    // ------------------------------------------------------------------
    // bus read side
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            disk_log_pkg::OFF_SNUM_CUR: rd_word[7:0] = hob_q ? unc_lba_q[31:24] : unc_lba_q[7:0];
            disk_log_pkg::OFF_CYLLO_CUR: rd_word[7:0] = hob_q ? unc_lba_q[39:32] : unc_lba_q[15:8];
            disk_log_pkg::OFF_CYLHI_CUR: rd_word[7:0] = hob_q ? unc_lba_q[47:40] : unc_lba_q[23:16];
            disk_log_pkg::OFF_CMD_STATUS: begin
                rd_word[disk_log_pkg::ST_BSY] = busy && !drq_q;
                rd_word[disk_log_pkg::ST_RDY] = 1'b1;
                rd_word[disk_log_pkg::ST_DSC] = 1'b1;
                rd_word[disk_log_pkg::ST_DRQ] = drq_q;
                rd_word[disk_log_pkg::ST_ERR] = err_abt_q || err_unc_q;
            end
            disk_log_pkg::OFF_ERROR: begin
                rd_word[disk_log_pkg::ER_ABT] = err_abt_q;
                rd_word[disk_log_pkg::ER_UNC] = err_unc_q;
            end
            disk_log_pkg::OFF_DEVCTL: rd_word[disk_log_pkg::DC_HOB] = hob_q;
            disk_log_pkg::OFF_DATA: rd_word = 32'h0000_0000;
            default: begin
                if (s_axi_araddr[1:0] == 2'h0 && 32'(s_axi_araddr[5:2]) < disk_log_pkg::TF_REGS &&
                    !s_axi_araddr[7] && !s_axi_araddr[6]) begin
                    rd_word[7:0] = tf_q[s_axi_araddr[5:2]];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign status_read = s_axi_arvalid && !rvalid_q && s_axi_araddr == disk_log_pkg::OFF_CMD_STATUS;

    // read answer one cycle after the address is taken
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= disk_log_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? disk_log_pkg::RESP_OKAY : disk_log_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // data path to the media side
    // ------------------------------------------------------------------
    word_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_s(push_s),
        .out_s(drain_s)
    );
    assign media_valid = drain_s.valid;
    assign media_data = drain_s.data;
    assign drain_s.ready = media_ready;
endmodule
`default_nettype wire

/* bench/media_sink.sv */
// media-side partner: a stalling word sink with commit and error pulses
`timescale 1ns/10ps
`default_nettype none
module media_sink (
    input wire logic mclk,
    input wire logic media_valid,
    input wire logic commit_go,
    input wire logic unc_go,
    output var logic media_ready = 1'b0,
    output var logic media_commit_done = 1'b0,
    output var logic media_unc_err = 1'b0
);
    int seed = 24;
    // random stalls, a real medium is not always ready for the next word
    always @(posedge mclk) begin
        media_ready <= !media_valid || ($random(seed) % 4) != 0;
        media_commit_done <= commit_go;
        media_unc_err <= unc_go;
    end
endmodule
`default_nettype wire

/* bench/disk_write_log_command_logic_chk.sv */
// port-level assertions for the log write command logic
`timescale 1ns/10ps
`default_nettype none
module disk_write_log_command_logic_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic media_valid,
    input wire logic media_ready,
    input wire logic [31:0] media_data,
    input wire logic intrq,
    input wire logic busy,
    input wire logic log_write_active
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // bus steps: a request taken, then its single answer
    sequence wr_taken; s_axi_awvalid && s_axi_awready; endsequence
    sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
    chk_write_answer:
        assert property (wr_taken |=> s_axi_bvalid) else $error("write not answered");
    chk_read_answer:
        assert property (rd_taken |=> s_axi_rvalid) else $error("read not answered");
    chk_bresp_once:
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answered twice");
    chk_rdata_once:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answered twice");
    chk_arready_free:
        assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
    chk_done_irq:
        assert property ($fell(log_write_active) |-> intrq) else $error("no interrupt at end");
    chk_active_busy:
        assert property (log_write_active |-> busy) else $error("log write while idle");
    chk_media_hold:
        assert property (media_valid && !media_ready |=> media_valid && $stable(media_data))
        else $error("media word dropped");
endmodule
bind disk_write_log_command_logic disk_write_log_command_logic_chk i_chk (.mclk, .rst_n,
    .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .media_valid, .media_ready, .media_data,
    .intrq, .busy, .log_write_active);
`default_nettype wire

/* bench/disk_write_log_command_logic_bench.sv */
// self-checking bench for the log write command logic
`timescale 1ns/10ps
`default_nettype none
module disk_write_log_command_logic_bench;
    logic mclk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic write_cache_en = 1'b1, log_read_only = 1'b0, log_feature_ok = 1'b1;
    logic commit_go = 1'b0, unc_go = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, log_addr;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, media_data;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] log_dir_size = 16'h0004, log_start_sector;
    logic [47:0] media_unc_lba = 48'h0000_0000_0000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic log_write_active, media_valid, media_ready, media_commit_done, media_unc_err;
    logic intrq, busy;
    logic [33:0] eq_r[$];
    logic [1:0] eq_b[$];
    logic [31:0] eq_m[$];
    int fail_count = 0, checks = 0, seed = 24, n;

    disk_write_log_command_logic #(.FIFO_DEPTH(32), .BLOCK_SECTORS(1)) i_dut (.*);
    media_sink i_sink (.mclk(mclk), .media_valid(media_valid), .commit_go(commit_go),
        .unc_go(unc_go), .media_ready(media_ready), .media_commit_done(media_commit_done),
        .media_unc_err(media_unc_err));

    always #20 mclk = ~mclk;

    task automatic print_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // every wait is bounded; running out counts as a mismatch
    task automatic guard();
        n++;
        if (n > 3000) begin
            cmp(34'h0_0000_0000, 34'h0_0000_0001);
            print_verdict();
        end
    endtask

    // answers and media words against the oldest note
    always @(posedge mclk) begin
        if (s_axi_rvalid && s_axi_rready)
            cmp({s_axi_rresp, s_axi_rdata}, eq_r.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            cmp({32'h0000_0000, s_axi_bresp}, {32'h0000_0000, eq_b.pop_front()});
        if (media_valid && media_ready)
            cmp({2'h0, media_data}, {2'h0, eq_m.pop_front()});
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        @(posedge mclk);
        eq_b.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin @(posedge mclk); guard(); end while ({s_axi_awready, s_axi_wready} !== 2'b11);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do begin @(posedge mclk); guard(); end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        eq_r.push_back({2'h0, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin @(posedge mclk); guard(); end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do begin @(posedge mclk); guard(); end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    // one sector of random words, first word lowest bytes
    task automatic sector();
        logic [31:0] w;
        for (int i = 0; i < disk_log_pkg::WORDS_PER_SECTOR; i++) begin
            w = $random(seed);
            eq_m.push_back(w);
            wr(8'h38, w);
        end
    endtask

    task automatic wait_idle();
        n = 0;
        while (busy !== 1'b0) begin @(posedge mclk); guard(); end
    endtask

    task automatic log_cmd(input logic [15:0] c, input logic [15:0] s, input logic [7:0] op);
        wr(8'h08, 32'(c[7:0]));
        wr(8'h0C, 32'(c[15:8]));
        wr(8'h18, 32'(s[7:0]));
        wr(8'h1C, 32'(s[15:8]));
        wr(8'h2C, 32'(op));
    endtask

    initial begin
        logic [15:0] c;
        logic [47:0] lba;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'h30, 32'h0000_0000);
        wr(8'h3C, 32'h0000_0000, disk_log_pkg::RESP_SLVERR);
        $display("test reset done");
        // zero count, oversize count, read-only, feature off, range end past size, bad opcode; no word may reach the media
        for (int i = 0; i < 6; i++) begin
            log_dir_size <= (i == 1) ? 16'h0100 : 16'h0004;
            log_read_only <= (i == 2);
            log_feature_ok <= (i != 3);
            c = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0101 : 16'h0002;
            log_cmd(c, (i == 4) ? 16'h0003 : 16'h0000, (i == 5) ? 8'hEE : 8'h3F);
            rd(8'h2C, 32'h0000_0051);
            rd(8'h30, 32'h0000_0004);
        end
        $display("test aborts done");
        // two sectors, an interrupt for each, log and start forwarded
        log_dir_size <= 16'h0105;
        log_read_only <= 1'b0;
        log_feature_ok <= 1'b1;
        wr(8'h10, 32'h0000_00A5);
        log_cmd(16'h0002, 16'h0102, disk_log_pkg::CMD_WRITE_LOG_EXT);
        cmp({26'h0, log_addr}, {26'h0, 8'hA5});
        cmp({18'h0, log_start_sector}, {18'h0, 16'h0102});
        sector();
        n = 0;
        while (intrq !== 1'b1) begin @(posedge mclk); guard(); end
        rd(8'h2C, 32'h0000_0058);
        sector();
        wait_idle();
        rd(8'h2C, 32'h0000_0050);
        rd(8'h30, 32'h0000_0000);
        $display("test log write done");
        // queued write hit by an unrecoverable error, address in both views
        lba = {16'($random(seed)), 32'($random(seed))};
        media_unc_lba <= lba;
        wr(8'h00, 32'h0000_0001);
        wr(8'h2C, 32'(disk_log_pkg::CMD_WRITE_FPDMA));
        unc_go <= 1'b1;
        @(posedge mclk);
        unc_go <= 1'b0;
        wait_idle();
        rd(8'h30, 32'h0000_0040);
        for (int h = 0; h < 2; h++) begin
            wr(8'h34, h ? 32'h0000_0080 : 32'h0000_0000);
            rd(8'h10, 32'(lba[h*24 +: 8]));
            rd(8'h18, 32'(lba[h*24+8 +: 8]));
            rd(8'h20, 32'(lba[h*24+16 +: 8]));
        end
        $display("test error address done");
        // fua holds completion for the commit, cached write does not
        for (int f = 0; f < 2; f++) begin
            wr(8'h28, f ? 32'h0000_0000 : 32'h0000_0080);
            wr(8'h2C, 32'(disk_log_pkg::CMD_WRITE_FPDMA));
            sector();
            repeat (100) @(posedge mclk);
            cmp({33'h0, busy}, {33'h0, f == 0});
            commit_go <= 1'b1;
            @(posedge mclk);
            wait_idle();
            commit_go <= 1'b0;
        end
        $display("test completion done");
        print_verdict();
    end
endmodule
`default_nettype wire
